//--- rtl/fms_pkg.sv
// Shared constants for the fixed-point multiply sequencer
package fms_pkg;
    localparam int          DATA_W       = 32;
    localparam int          PP_W         = 36;
    localparam int          ADDR_W       = 8;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_INSTR    = 8'h04;
    localparam logic [7:0]  OFS_OPADDR   = 8'h08;
    localparam logic [7:0]  OFS_MS_LEFT  = 8'h0c;
    localparam logic [7:0]  OFS_MS_RIGHT = 8'h10;
    localparam logic [7:0]  OFS_STATUS   = 8'h14;
    localparam logic [7:0]  OFS_GR_BASE  = 8'h40;
    // Field positions
    localparam int          CTRL_START_BIT   = 0;
    localparam int          ST_BUSY_BIT      = 0;
    localparam int          ST_DONE_BIT      = 1;
    localparam int          ST_SPEC_BIT      = 2;
    localparam int          ST_MSRDY_BIT     = 3;
    localparam int          OPADDR_WORD_BIT  = 10;
    // Opcodes of the two supported forms
    localparam logic [7:0]  OP_REG_FORM  = 8'h1c;
    localparam logic [7:0]  OP_STOR_FORM = 8'h5c;
    // Reset and initial values, and step compare values
    localparam logic [3:0]  STEP_INIT    = 4'hf;
    localparam logic [2:0]  BYTE_INIT    = 3'h3;
    localparam logic [3:0]  STEP_LAST_SEL = 4'h1;
    localparam logic [3:0]  STEP_TERM_SEL = 4'h0;
    localparam logic [3:0]  STEP_TERM_SHF = 4'hf;
    localparam logic [3:0]  STEP_TERM_END = 4'he;
    localparam logic [31:0] REG_RESET    = 32'h0000_0000;

    typedef enum logic [9:0] {
        ST_IDLE    = 10'h001,
        ST_CHECK   = 10'h002,
        ST_LOAD    = 10'h004,
        ST_SEL     = 10'h008,
        ST_TERM    = 10'h010,
        ST_MOVE_HI = 10'h020,
        ST_WR_HI   = 10'h040,
        ST_MOVE_LO = 10'h080,
        ST_WR_LO   = 10'h100,
        ST_ENDOP   = 10'h200
    } fms_state_e;
endpackage

//--- rtl/fms_multiple_select.sv
// Picks the multiple of the multiplicand from a bit-pair and the carry flag
module fms_multiple_select
    import fms_pkg::*;
(
    input  wire logic [1:0]        pair,
    input  wire logic              carry,
    input  wire logic              last_sel,
    input  wire logic [DATA_W-1:0] mcand,
    output logic      [PP_W-1:0]   multiple,
    output logic                   carry_next
);
    logic [PP_W-1:0] times_one;
    logic [PP_W-1:0] times_two;

    always_comb begin
        times_one  = {{(PP_W-DATA_W){mcand[DATA_W-1]}}, mcand};
        times_two  = {times_one[PP_W-2:0], 1'b0};
        multiple   = '0;
        carry_next = 1'b0;
        unique case ({carry, pair})
            3'b000: multiple = '0;
            3'b001: multiple = times_one;
            3'b010: begin
                // Top pair 10 is a negative digit; -2 keeps the sign right
                multiple = last_sel ? ~times_two + 1'b1
                                    : times_two;
            end
            3'b011: begin
                multiple   = ~times_one + 1'b1;
                carry_next = 1'b1;
            end
            3'b100: multiple = times_one;
            3'b101: multiple = times_two;
            3'b110: begin
                multiple   = ~times_one + 1'b1;
                carry_next = 1'b1;
            end
            3'b111: begin
                multiple   = '0;
                carry_next = 1'b1;
            end
        endcase
    end
endmodule

//--- rtl/fms_byte_merge.sv
// Byte assembly path: merges product bit-pairs into the partial byte
module fms_byte_merge (
    input  wire logic [1:0] pair,
    input  wire logic [1:0] step_low,
    input  wire logic [7:0] partial,
    output logic      [7:0] partial_next,
    output logic      [7:0] full_byte,
    output logic            byte_done
);
    always_comb begin
        partial_next = partial;
        full_byte    = {pair, partial[5:0]};
        byte_done    = 1'b0;
        unique case (step_low)
            2'b01: partial_next = {6'h00, pair};
            2'b00: partial_next[3:2] = pair;
            2'b11: partial_next[5:4] = pair;
            2'b10: byte_done = 1'b1;
        endcase
    end
endmodule

//--- rtl/fms_multiply_sequencer.sv
// Fixed-point multiply datapath and microsequence with APB access
//
// The APB interface to the registers and the placing of the registers were decided locally.
module fms_multiply_sequencer
    import fms_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);
    ////////////////////////////////////////////////////////////////////////
    fms_state_e        state_q;
    fms_state_e        state_d;
    logic [15:0]       instr_q;
    logic [31:0]       opaddr_q;
    logic [31:0]       ms_left_q;
    logic [31:0]       ms_right_q;
    logic              ms_ready_q;
    logic              done_q;
    logic              spec_q;
    logic [31:0]       general_register_q [16];
    logic [31:0]       s_q;
    logic [31:0]       t_q;
    logic [PP_W-1:0]   adder_output_latch_q;
    logic              tx_q;
    logic [3:0]        step_q;
    logic [2:0]        byte_position_counter_q;
    logic [7:0]        partial_byte_q;
    logic [1:0]        pair_q;
    logic              pair_valid_q;
    logic              seen_q;
    logic              select_bit_high;
    logic              select_bit_low;

    logic [3:0]        first_operand_field;
    logic [3:0]        second_field;
    logic [3:0]        odd_field;
    logic              bus_setup;
    logic              bus_write;
    logic              bus_read_ok;
    logic              gr_hit;
    logic              start_req;
    logic              do_sel;
    logic              do_shift;
    logic              last_sel;
    logic [PP_W-1:0]   multiple;
    logic              tx_next;
    logic [PP_W-1:0]   shifted_pp;
    logic [7:0]        partial_next;
    logic [7:0]        full_byte;
    logic              byte_done;
    logic [31:0]       read_mux;
    logic              addr_ok;

    assign first_operand_field = instr_q[7:4];
    assign second_field        = instr_q[3:0];
    assign odd_field           = {first_operand_field[3:1], 1'b1};

    ////////////////////////////////////////////////////////////////////////
    // APB slave: registered answer, ready in the first access cycle with no wait cycle
    assign bus_setup = psel && !penable;
    assign bus_write = psel && penable && pready && pwrite;
    assign gr_hit    = (paddr[7:6] == OFS_GR_BASE[7:6]) && (paddr[1:0] == 2'b00);
    assign start_req = bus_write && (paddr == OFS_CTRL) && pwdata[CTRL_START_BIT];

    always_comb begin
        addr_ok  = 1'b1;
        read_mux = REG_RESET;
        if (gr_hit) begin
            read_mux = general_register_q[paddr[5:2]];
        end else begin
            unique case (paddr)
                OFS_CTRL:     read_mux[ST_BUSY_BIT] = (state_q != ST_IDLE);
                OFS_INSTR:    read_mux[15:0] = instr_q;
                OFS_OPADDR:   read_mux = opaddr_q;
                OFS_MS_LEFT:  read_mux = ms_left_q;
                OFS_MS_RIGHT: read_mux = ms_right_q;
                OFS_STATUS: begin
                    read_mux[ST_BUSY_BIT]  = (state_q != ST_IDLE);
                    read_mux[ST_DONE_BIT]  = done_q;
                    read_mux[ST_SPEC_BIT]  = spec_q;
                    read_mux[ST_MSRDY_BIT] = ms_ready_q;
                end
                default: addr_ok = 1'b0;
            endcase
        end
    end

    assign bus_read_ok = addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= REG_RESET;
        end else begin
            pready  <= bus_setup;
            pslverr <= bus_setup && !bus_read_ok;
            // Read data stands only in the access cycle, zero otherwise
            if (bus_setup && !pwrite) begin
                prdata <= read_mux;
            end else begin
                prdata <= REG_RESET;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q    <= 16'h0000;
            opaddr_q   <= REG_RESET;
            ms_left_q  <= REG_RESET;
            ms_right_q <= REG_RESET;
        end else if (bus_write) begin
            // Operand set-up registers are frozen while the multiply runs
            if (state_q == ST_IDLE) begin
                if (paddr == OFS_INSTR)    instr_q    <= pwdata[15:0];
                if (paddr == OFS_OPADDR)   opaddr_q   <= pwdata;
                if (paddr == OFS_MS_LEFT)  ms_left_q  <= pwdata;
                if (paddr == OFS_MS_RIGHT) ms_right_q <= pwdata;
            end
        end
    end

    // Writing the right word marks the storage fetch as delivered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_ready_q <= 1'b0;
        end else if (bus_write && paddr == OFS_MS_RIGHT && state_q == ST_IDLE) begin
            ms_ready_q <= 1'b1;
        end else if (state_q == ST_LOAD && instr_q[15:8] == OP_STOR_FORM) begin
            ms_ready_q <= 1'b0;
        end
    end

    // Status flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            spec_q <= 1'b0;
        end else begin
            if (state_q == ST_ENDOP) begin
                done_q <= 1'b1;
            end else if (bus_write && paddr == OFS_STATUS && pwdata[ST_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (state_q == ST_CHECK && state_d == ST_IDLE) begin
                spec_q <= 1'b1;
            end else if (bus_write && paddr == OFS_STATUS && pwdata[ST_SPEC_BIT]) begin
                spec_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (start_req) state_d = ST_CHECK;
            ST_CHECK: begin
                if (first_operand_field[0] ||
                    (instr_q[15:8] != OP_REG_FORM &&
                     instr_q[15:8] != OP_STOR_FORM)) begin
                    state_d = ST_IDLE;
                end else begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (instr_q[15:8] == OP_REG_FORM || ms_ready_q) begin
                    state_d = ST_SEL;
                end
            end
            ST_SEL:     if (step_q == STEP_LAST_SEL) state_d = ST_TERM;
            ST_TERM:    if (step_q == STEP_TERM_END) state_d = ST_MOVE_HI;
            ST_MOVE_HI: state_d = ST_WR_HI;
            ST_WR_HI:   state_d = ST_MOVE_LO;
            ST_MOVE_LO: state_d = ST_WR_LO;
            ST_WR_LO:   state_d = ST_ENDOP;
            ST_ENDOP:   state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Datapath
    assign do_sel   = (state_q == ST_SEL) ||
                      (state_q == ST_TERM && step_q == STEP_TERM_SEL);
    assign do_shift = do_sel ||
                      (state_q == ST_TERM && step_q == STEP_TERM_SHF);
    assign last_sel = (state_q == ST_TERM);
    // Step bits pick the byte, then the pair in it, lowest first
    assign {select_bit_high, select_bit_low} = s_q[{~step_q, 1'b0} +: 2];
    // Arithmetic shift keeps the sign as a high-order extension
    assign shifted_pp = $signed(adder_output_latch_q) >>> 2;

    fms_multiple_select u_select (
        .pair       ({select_bit_high, select_bit_low}),
        .carry      (tx_q),
        .last_sel   (last_sel),
        .mcand      (t_q),
        .multiple   (multiple),
        .carry_next (tx_next)
    );

    fms_byte_merge u_merge (
        .pair         (pair_q),
        .step_low     (step_q[1:0]),
        .partial      (partial_byte_q),
        .partial_next (partial_next),
        .full_byte    (full_byte),
        .byte_done    (byte_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adder_output_latch_q <= '0;
            tx_q                 <= 1'b0;
            pair_q               <= 2'b00;
            pair_valid_q         <= 1'b0;
            seen_q               <= 1'b0;
        end else if (state_q == ST_CHECK) begin
            adder_output_latch_q <= '0;
            tx_q                 <= 1'b0;
            pair_valid_q         <= 1'b0;
            seen_q               <= 1'b0;
        end else begin
            pair_valid_q <= do_shift && seen_q;
            if (do_shift) begin
                // The pair shifted out now is merged next cycle: 1-cycle lag
                pair_q               <= adder_output_latch_q[1:0];
                adder_output_latch_q <= shifted_pp + (do_sel ? multiple : '0);
            end
            if (do_sel) begin
                tx_q   <= tx_next;
                seen_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q                  <= STEP_INIT;
            byte_position_counter_q <= BYTE_INIT;
            partial_byte_q          <= 8'h00;
        end else if (state_q == ST_CHECK) begin
            step_q                  <= STEP_INIT;
            byte_position_counter_q <= BYTE_INIT;
            partial_byte_q          <= 8'h00;
        end else if (state_q == ST_SEL || state_q == ST_TERM) begin
            // Step wraps 0000 to 1111 to 1110 during termination
            step_q <= step_q - 4'h1;
            if (pair_valid_q) begin
                partial_byte_q <= partial_next;
                if (byte_done) begin
                    byte_position_counter_q <= byte_position_counter_q - 3'h1;
                end
            end
        end
    end

    // Multiplier/product and multiplicand registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= REG_RESET;
            t_q <= REG_RESET;
        end else begin
            unique case (state_q)
                ST_LOAD: begin
                    if (instr_q[15:8] == OP_REG_FORM) begin
                        s_q <= general_register_q[second_field];
                        t_q <= general_register_q[odd_field];
                    end else if (ms_ready_q) begin
                        s_q <= general_register_q[odd_field];
                        t_q <= opaddr_q[OPADDR_WORD_BIT] ? ms_right_q
                                                         : ms_left_q;
                    end
                end
                ST_SEL, ST_TERM: begin
                    if (pair_valid_q && byte_done) begin
                        // Each finished byte goes straight from the assembly path
                        s_q[{~byte_position_counter_q[1:0], 3'b000} +: 8]
                            <= full_byte;
                    end
                end
                ST_MOVE_HI: t_q <= adder_output_latch_q[31:0];
                ST_MOVE_LO: t_q <= s_q;
                default: ;
            endcase
        end
    end

    // General registers, shared between software and the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 16; i++) begin
                general_register_q[i] <= REG_RESET;
            end
        end else if (state_q == ST_WR_HI) begin
            general_register_q[first_operand_field] <= t_q;
        end else if (state_q == ST_WR_LO) begin
            general_register_q[odd_field] <= t_q;
        end else if (bus_write && gr_hit && state_q == ST_IDLE) begin
            general_register_q[paddr[5:2]] <= pwdata;
        end
    end
endmodule

//--- verification/fms_apb_host.sv
// APB master standing in for the software side of the sequencer
module fms_apb_host
    import fms_pkg::*;
(
    input  wire logic              pclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [31:0]       pwdata,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No fixed latency assumed: waits for pready, only the bench timeout bounds the wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle bus carries junk so stale values never look valid
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

//--- verification/fms_multiply_sequencer_properties.sv
// Port-level checks of the APB slave behaviour
module fms_multiply_sequencer_properties
    import fms_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    property p_setup_answer;
        s_setup |=> s_access;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    property p_rdata_idle;
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    property p_rdata_write;
        pready && pwrite |-> prdata == 32'h0000_0000;
    endproperty
    property p_err_qual;
        pslverr |-> pready;
    endproperty
    property p_err_unmapped;
        pready && (paddr inside {[8'h18:8'h3f]} || paddr >= 8'h80)
            |-> pslverr && prdata == 32'h0000_0000;
    endproperty
    property p_mapped_ok;
        pready && paddr[1:0] == 2'h0
            && (paddr <= OFS_STATUS || paddr inside {[8'h40:8'h7c]})
            |-> !pslverr;
    endproperty

    a_setup_answer:    assert property (p_setup_answer)
        else $error("no access answer one cycle after setup");
    a_ready_pulse:     assert property (p_ready_pulse)
        else $error("pready held longer than one cycle");
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("pready outside access phase");
    a_rdata_idle:      assert property (p_rdata_idle)
        else $error("read data not zero while idle");
    a_rdata_write:     assert property (p_rdata_write)
        else $error("read data not zero on write");
    a_err_qual:        assert property (p_err_qual)
        else $error("pslverr without pready");
    a_err_unmapped:    assert property (p_err_unmapped)
        else $error("unmapped address not refused");
    a_mapped_ok:       assert property (p_mapped_ok)
        else $error("mapped address refused");
endmodule

bind fms_multiply_sequencer fms_multiply_sequencer_properties
    fms_multiply_sequencer_properties_i (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
);

//--- verification/fms_multiply_sequencer_tb_top.sv
// Self-checking bench: multiplies through APB against a longint model
`define CHK(g, x) begin checks_done++; if ((g) !== (x)) begin \
    num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, x); \
    end end
module fms_multiply_sequencer_tb_top;
    import fms_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic [31:0]       gr_m [16];
    int                num_errors = 0;
    int                checks_done = 0;
    int                cyc = 0;
    int                seed = 86;

    always #4 pclk = ~pclk;

    fms_multiply_sequencer fms_multiply_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    fms_apb_host fms_apb_host_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard well above the fewer than two thousand cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            finish_test();
        end
    end

    function automatic logic [7:0] gra(input logic [3:0] n);
        return OFS_GR_BASE + {2'h0, n, 2'h0};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        fms_apb_host_i.xfer(1'b1, a, d, r, e);
        `CHK(e, 1'b0)
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        fms_apb_host_i.xfer(1'b0, a, 32'h0000_0000, r, e);
        `CHK(e, 1'b0)
    endtask

    task automatic wait_idle(output logic [31:0] st);
        int n;
        for (n = 0; n < 60; n++) begin
            rd(OFS_STATUS, st);
            if (st[ST_BUSY_BIT] === 1'b0) break;
        end
    endtask

    // a goes to the odd register of the pair, b is the other operand
    task automatic run_mul(input logic stor, input logic right,
                           input logic [3:0] fop, input logic [31:0] a,
                           input logic [31:0] b);
        logic [31:0] st, v;
        logic [3:0]  sop;
        longint      p;
        sop = fop + 4'h2;
        if (stor) begin
            wr(OFS_OPADDR, {21'h0, right, 10'h0});
            wr(OFS_MS_LEFT, right ? ~b : b);
            wr(OFS_MS_RIGHT, right ? b : ~b);
        end else begin
            wr(gra(sop), b);
            gr_m[sop] = b;
        end
        wr(gra(fop + 4'h1), a);
        wr(OFS_INSTR, {16'h0, stor ? OP_STOR_FORM : OP_REG_FORM, fop, sop});
        rd(OFS_STATUS, st);
        `CHK(st[ST_MSRDY_BIT], stor)
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_STATUS, st);
        `CHK(st[ST_BUSY_BIT], 1'b1)
        wr(gra(sop), ~b);
        wait_idle(st);
        `CHK(st[ST_DONE_BIT], 1'b1)
        `CHK(st[ST_MSRDY_BIT], 1'b0)
        p = longint'($signed(a)) * longint'($signed(b));
        rd(gra(fop), v);
        `CHK(v, p[63:32])
        rd(gra(fop + 4'h1), v);
        `CHK(v, p[31:0])
        gr_m[fop] = p[63:32];
        gr_m[fop + 4'h1] = p[31:0];
        rd(gra(sop), v);
        `CHK(v, gr_m[sop])
        wr(OFS_STATUS, 32'h0000_0002);
        rd(OFS_STATUS, st);
        `CHK(st, 32'h0000_0000)
    endtask

    task automatic run_bad(input logic [15:0] ins);
        logic [31:0] st, v;
        wr(OFS_INSTR, {16'h0, ins});
        wr(OFS_CTRL, 32'h0000_0001);
        wait_idle(st);
        `CHK(st[ST_SPEC_BIT], 1'b1)
        `CHK(st[ST_DONE_BIT], 1'b0)
        rd(gra(ins[7:4]), v);
        `CHK(v, gr_m[ins[7:4]])
        wr(OFS_STATUS, 32'h0000_0004);
        rd(OFS_STATUS, st);
        `CHK(st, 32'h0000_0000)
    endtask

    logic [31:0] ta [8] = '{32'd26, 32'hffff_ffe6, 32'h0, 32'h8000_0000,
        32'h7fff_ffff, 32'hffff_ffff, 32'h5555_5555, 32'h0000_0001};
    logic [31:0] tb [8] = '{32'd163, 32'hffff_ff5d, 32'hffff_ffff,
        32'h8000_0000, 32'h8000_0000, 32'hffff_ffff, 32'haaaa_aaaa,
        32'hbfff_ffff};

    initial begin
        logic [31:0] v, a, b;
        logic        e;
        int          i;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_STATUS, v);
        `CHK(v, REG_RESET)
        for (i = 0; i < 16; i++) begin
            gr_m[i] = REG_RESET;
            rd(gra(4'(i)), v);
            `CHK(v, REG_RESET)
        end
        // Unmapped words just past the status word and above the registers
        for (i = 0; i < 8; i++) begin
            fms_apb_host_i.xfer(i[0], {i[2], 7'h18 + 7'(i * 4)}, ta[i], v, e);
            `CHK(e, 1'b1)
            `CHK(v, 32'h0000_0000)
        end
        for (i = 0; i < 24; i++) begin
            a = (i < 8) ? ta[i] : $random(seed);
            b = (i < 8) ? tb[i] : $random(seed);
            run_mul(i[0], i[1], 4'(2 * (i % 8)), a, b);
        end
        run_bad({OP_REG_FORM, 4'h3, 4'h4});
        run_bad({OP_STOR_FORM, 4'hf, 4'h0});
        run_bad({8'h1d, 4'h2, 4'h4});
        finish_test();
    end
endmodule
